// ---- rtl/prio_pkg.sv ----
// constants for the five-register interrupt priority bank
// assumes a 32-bit axi4-lite master and one 50 MHz clock
package prio_pkg;
   localparam int NUM_REGS    = 5;
   localparam int FLD_PER_REG = 4;
   localparam int NUM_SRC     = NUM_REGS * FLD_PER_REG;
   localparam int FLD_W       = 3;
   localparam int REG_W       = 16;
   localparam int ADDR_W      = 8;
   // byte offsets of the five registers
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_6  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_7  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_8  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_9  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_10 = 8'h10;
   localparam logic [ADDR_W-1:0] REG_OFS [NUM_REGS] = '{
      OFS_PRIO_CTRL_6, OFS_PRIO_CTRL_7, OFS_PRIO_CTRL_8,
      OFS_PRIO_CTRL_9, OFS_PRIO_CTRL_10};
   // field low bit by slot, slot 0 is the top field
   localparam int FLD_LSB [FLD_PER_REG] = '{12, 8, 4, 0};
   localparam logic [FLD_W-1:0] PRIO_RESET   = 3'h4;
   localparam logic [FLD_W-1:0] PRIO_OFF     = 3'h0;
   localparam logic [1:0]       RESP_OKAY    = 2'h0;
   localparam logic [1:0]       RESP_SLVERR  = 2'h2;
endpackage

// ---- rtl/prio_reg_if.sv ----
// register access path between bus slave and priority bank
// assumes both ends on the same clock
`timescale 1ns/1ns
interface prio_reg_if;
   logic                        wr_en;
   logic [2:0]                  wr_idx;
   logic [prio_pkg::REG_W-1:0]  wr_data;
   logic [1:0]                  wr_strb;
   logic [2:0]                  rd_idx;
   logic [prio_pkg::REG_W-1:0]  rd_data;
   modport slave (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                  input rd_data);
   modport bank  (input wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                  output rd_data);
endinterface

// ---- rtl/prio_axil_slave.sv ----
// axi4-lite slave that turns bus accesses into register strobes
// assumes one outstanding write and one outstanding read
`timescale 1ns/1ns
module prio_axil_slave (
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        srst,
   // write address and data
   input  wire logic [prio_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                        awvalid,
   output      logic                        awready,
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output      logic                        wready,
   // write response
   output      logic [1:0]                  bresp,
   output      logic                        bvalid,
   input  wire logic                        bready,
   // read
   input  wire logic [prio_pkg::ADDR_W-1:0] araddr,
   input  wire logic                        arvalid,
   output      logic                        arready,
   output      logic [31:0]                 rdata,
   output      logic [1:0]                  rresp,
   output      logic                        rvalid,
   input  wire logic                        rready,
   // register side
   prio_reg_if.slave                        regs
);
   typedef struct packed {
      logic                        aw_have;
      logic [prio_pkg::ADDR_W-1:0] awaddr;
      logic                        w_have;
      logic [prio_pkg::REG_W-1:0]  wdata;
      logic [1:0]                  wstrb;
      logic                        awready;
      logic                        wready;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        rpend;
      logic [prio_pkg::ADDR_W-1:0] araddr;
      logic                        arready;
      logic                        rvalid;
      logic [31:0]                 rdata;
      logic [1:0]                  rresp;
   } slv_s;

   slv_s st_q;
   slv_s st_d;

   // address to register index, bit 3 flags a hit
   function automatic logic [3:0] decode(
      input logic [prio_pkg::ADDR_W-1:0] a);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < prio_pkg::NUM_REGS; i++)
      begin
         if (a == prio_pkg::REG_OFS[i])
         begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   logic [3:0] wdec;
   logic [3:0] rdec;
   logic       wr_go;

   assign wdec  = decode(st_q.awaddr);
   assign rdec  = decode(st_q.araddr);
   assign wr_go = st_q.aw_have && st_q.w_have && !st_q.bvalid;

   assign regs.wr_en   = wr_go && wdec[3];
   assign regs.wr_idx  = wdec[2:0];
   assign regs.wr_data = st_q.wdata;
   assign regs.wr_strb = st_q.wstrb;
   assign regs.rd_idx  = rdec[2:0];

   always_comb
   begin
      st_d = st_q;
      if (awvalid && st_q.awready)
      begin
         st_d.aw_have = 1'b1;
         st_d.awaddr  = awaddr;
      end
      if (wvalid && st_q.wready)
      begin
         st_d.w_have = 1'b1;
         st_d.wdata  = wdata[15:0];
         st_d.wstrb  = wstrb[1:0];
      end
      if (st_q.bvalid && bready)
      begin
         st_d.bvalid = 1'b0;
      end
      if (wr_go)
      begin
         st_d.bvalid  = 1'b1;
         st_d.bresp   = wdec[3] ? prio_pkg::RESP_OKAY
                                : prio_pkg::RESP_SLVERR;
         st_d.aw_have = 1'b0;
         st_d.w_have  = 1'b0;
      end
      st_d.awready = !st_d.aw_have && !st_d.bvalid;
      st_d.wready  = !st_d.w_have && !st_d.bvalid;
      if (arvalid && st_q.arready)
      begin
         st_d.rpend  = 1'b1;
         st_d.araddr = araddr;
      end
      if (st_q.rvalid && rready)
      begin
         st_d.rvalid = 1'b0;
      end
      if (st_q.rpend)
      begin
         st_d.rpend  = 1'b0;
         st_d.rvalid = 1'b1;
         st_d.rdata  = rdec[3] ? {16'h0000, regs.rd_data} : 32'h0000_0000;
         st_d.rresp  = rdec[3] ? prio_pkg::RESP_OKAY
                               : prio_pkg::RESP_SLVERR;
      end
      st_d.arready = !st_d.rpend && !st_d.rvalid;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign awready = st_q.awready;
   assign wready  = st_q.wready;
   assign bvalid  = st_q.bvalid;
   assign bresp   = st_q.bresp;
   assign arready = st_q.arready;
   assign rvalid  = st_q.rvalid;
   assign rdata   = st_q.rdata;
   assign rresp   = st_q.rresp;
endmodule

// ---- rtl/prio_bank.sv ----
// five priority control registers with per-source priority outputs
// assumes axi4-lite master and source flags synchronous to core_clk
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module prio_bank #(
   parameter int NUM_SRC = prio_pkg::NUM_SRC
) (
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        srst,
   // axi4-lite write
   input  wire logic [prio_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                        awvalid,
   output      logic                        awready,
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output      logic                        wready,
   output      logic [1:0]                  bresp,
   output      logic                        bvalid,
   input  wire logic                        bready,
   // axi4-lite read
   input  wire logic [prio_pkg::ADDR_W-1:0] araddr,
   input  wire logic                        arvalid,
   output      logic                        arready,
   output      logic [31:0]                 rdata,
   output      logic [1:0]                  rresp,
   output      logic                        rvalid,
   input  wire logic                        rready,
   // source flags and gated requests
   input  wire logic [NUM_SRC-1:0]          source_flag,
   output      logic [NUM_SRC-1:0]          source_request,
   // priorities to the arbiter
   output      logic [2:0]                  timer4_priority,
   output      logic [2:0]                  out_compare4_priority,
   output      logic [2:0]                  out_compare3_priority,
   output      logic [2:0]                  dma_chan2_priority,
   output      logic [2:0]                  uart2_tx_priority,
   output      logic [2:0]                  uart2_rx_priority,
   output      logic [2:0]                  ext_irq2_priority,
   output      logic [2:0]                  timer5_priority,
   output      logic [2:0]                  can1_event_priority,
   output      logic [2:0]                  can1_rx_priority,
   output      logic [2:0]                  spi2_event_priority,
   output      logic [2:0]                  spi2_error_priority,
   output      logic [2:0]                  in_capture5_priority,
   output      logic [2:0]                  in_capture4_priority,
   output      logic [2:0]                  in_capture3_priority,
   output      logic [2:0]                  dma_chan3_priority,
   output      logic [2:0]                  out_compare7_priority,
   output      logic [2:0]                  out_compare6_priority,
   output      logic [2:0]                  out_compare5_priority,
   output      logic [2:0]                  in_capture6_priority
);
   typedef struct packed {
      logic [NUM_SRC-1:0][prio_pkg::FLD_W-1:0] prio;
      logic [NUM_SRC-1:0]                      req;
   } bank_s;

   bank_s st_q;
   bank_s st_d;

   logic [NUM_SRC-1:0][prio_pkg::FLD_W-1:0] fld_nxt;
   logic [NUM_SRC-1:0]                      req_nxt;
   logic [prio_pkg::NUM_REGS-1:0][prio_pkg::REG_W-1:0] rd_word;

   prio_reg_if regs ();

   prio_axil_slave u_slave (
      .core_clk (core_clk),
      .srst     (srst),
      .awaddr   (awaddr),
      .awvalid  (awvalid),
      .awready  (awready),
      .wdata    (wdata),
      .wstrb    (wstrb),
      .wvalid   (wvalid),
      .wready   (wready),
      .bresp    (bresp),
      .bvalid   (bvalid),
      .bready   (bready),
      .araddr   (araddr),
      .arvalid  (arvalid),
      .arready  (arready),
      .rdata    (rdata),
      .rresp    (rresp),
      .rvalid   (rvalid),
      .rready   (rready),
      .regs     (regs.slave)
   );

   for (genvar i = 0; i < NUM_SRC; i++)
   begin : g_fld
      localparam int REG  = i / prio_pkg::FLD_PER_REG;
      localparam int SLOT = i % prio_pkg::FLD_PER_REG;
      localparam int LSB  = prio_pkg::FLD_LSB[SLOT];
      localparam int LANE = LSB / 8;
      assign fld_nxt[i] = (regs.wr_en && regs.wr_idx == 3'(REG)
                           && regs.wr_strb[LANE])
                          ? regs.wr_data[LSB +: prio_pkg::FLD_W]
                          : st_q.prio[i];
      assign req_nxt[i] = source_flag[i]
                          && (st_q.prio[i] != prio_pkg::PRIO_OFF);
   end

   for (genvar r = 0; r < prio_pkg::NUM_REGS; r++)
   begin : g_rd
      assign rd_word[r] = {1'b0, st_q.prio[4*r],
                           1'b0, st_q.prio[4*r+1],
                           1'b0, st_q.prio[4*r+2],
                           1'b0, st_q.prio[4*r+3]};
   end

   assign regs.rd_data = (regs.rd_idx < 3'(prio_pkg::NUM_REGS))
                         ? rd_word[regs.rd_idx] : 16'h0000;

   always_comb
   begin
      st_d      = st_q;
      st_d.prio = fld_nxt;
      st_d.req  = req_nxt;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         st_q.prio <= {NUM_SRC{prio_pkg::PRIO_RESET}};
         st_q.req  <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign source_request = st_q.req;
   assign timer4_priority       = st_q.prio[0];
   assign out_compare4_priority = st_q.prio[1];
   assign out_compare3_priority = st_q.prio[2];
   assign dma_chan2_priority    = st_q.prio[3];
   assign uart2_tx_priority     = st_q.prio[4];
   assign uart2_rx_priority     = st_q.prio[5];
   assign ext_irq2_priority     = st_q.prio[6];
   assign timer5_priority       = st_q.prio[7];
   assign can1_event_priority   = st_q.prio[8];
   assign can1_rx_priority      = st_q.prio[9];
   assign spi2_event_priority   = st_q.prio[10];
   assign spi2_error_priority   = st_q.prio[11];
   assign in_capture5_priority  = st_q.prio[12];
   assign in_capture4_priority  = st_q.prio[13];
   assign in_capture3_priority  = st_q.prio[14];
   assign dma_chan3_priority    = st_q.prio[15];
   assign out_compare7_priority = st_q.prio[16];
   assign out_compare6_priority = st_q.prio[17];
   assign out_compare5_priority = st_q.prio[18];
   assign in_capture6_priority  = st_q.prio[19];
endmodule

// ---- sim/prio_bank_chk.sv ----
// assertions on the priority bank bus handshakes and outputs
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module prio_bank_chk #(
   parameter int NUM_SRC = 20
) (
   // clock and reset
   input wire logic               core_clk,
   input wire logic               srst,
   // bus handshakes
   input wire logic               awvalid,
   input wire logic               awready,
   input wire logic               wvalid,
   input wire logic               wready,
   input wire logic               bvalid,
   input wire logic               arvalid,
   input wire logic               arready,
   input wire logic               rvalid,
   input wire logic [31:0]        rdata,
   // sources and priorities
   input wire logic [NUM_SRC-1:0] source_flag,
   input wire logic [NUM_SRC-1:0] source_request,
   input wire logic [2:0]         timer4_priority,
   input wire logic [2:0]         in_capture6_priority
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   rd_zero_bits_a:
      assert property (rvalid |-> (rdata & 32'hFFFF_8888) == 32'h0)
      else $error("unimplemented read bits set");
   reset_default_a:
      assert property (disable iff (1'b0) srst |=> timer4_priority == 3'h4
         && in_capture6_priority == 3'h4 && source_request == '0)
      else $error("reset defaults wrong");
   req_disable_a:
      assert property (timer4_priority == 3'h0 |=> !source_request[0])
      else $error("disabled source requested");
   req_pass_a:
      assert property (source_flag[0] && timer4_priority != 3'h0
         |=> source_request[0])
      else $error("enabled source not requested");
   prio_change_a:
      assert property ($changed(in_capture6_priority) && !$past(srst)
         |-> $rose(bvalid))
      else $error("priority changed without write");
   wr_answer_a:
      assert property (awvalid && awready && wvalid && wready
         |-> ##[1:2] bvalid)
      else $error("write response missing");
   rd_answer_a:
      assert property (arvalid && arready |=> !arready ##[0:1] rvalid)
      else $error("read response missing");
   busy_refuse_a:
      assert property ((bvalid |-> !awready && !wready)
         and (rvalid |-> !arready))
      else $error("ready while response pending");

   cover property (awvalid && awready);
   cover property (timer4_priority == 3'h0 && source_flag[0]);
   cover property (disable iff (1'b0) srst ##1 !srst);
endmodule

// ---- sim/test_interrupt_priority_bank_6_to_10.sv ----
// self-checking bench for the priority bank over axi4-lite
// assumes prio_bank and prio_bank_chk compiled before
`timescale 1ns/1ns
module test_interrupt_priority_bank_6_to_10;
   logic        core_clk, srst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   logic [19:0] source_flag, source_request;
   logic [2:0]  pr [20];
   logic [15:0] m [5];
   logic [15:0] d;
   int          failures, total_checks, cycles, k;

   prio_bank dut_u (
      .core_clk(core_clk), .srst(srst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .source_flag(source_flag), .source_request(source_request),
      .timer4_priority(pr[0]), .out_compare4_priority(pr[1]),
      .out_compare3_priority(pr[2]), .dma_chan2_priority(pr[3]),
      .uart2_tx_priority(pr[4]), .uart2_rx_priority(pr[5]),
      .ext_irq2_priority(pr[6]), .timer5_priority(pr[7]),
      .can1_event_priority(pr[8]), .can1_rx_priority(pr[9]),
      .spi2_event_priority(pr[10]), .spi2_error_priority(pr[11]),
      .in_capture5_priority(pr[12]), .in_capture4_priority(pr[13]),
      .in_capture3_priority(pr[14]), .dma_chan3_priority(pr[15]),
      .out_compare7_priority(pr[16]), .out_compare6_priority(pr[17]),
      .out_compare5_priority(pr[18]), .in_capture6_priority(pr[19])
   );

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic conclude;
   begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
   begin
      total_checks++;
      if (seen !== want)
      begin
         failures++;
         $display("ERROR %0t seen %h want %h", $time, seen, want);
      end
   end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [3:0] s);
      bit aw, w;
   begin
      aw = 1'b0;
      w = 1'b0;
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge core_clk);
         aw |= awready;
         w |= wready;
         awvalid <= !aw;
         wvalid <= !w;
      end
      do @(posedge core_clk); while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
      @(posedge core_clk);
   end
   endtask

   task automatic rd(input logic [7:0] a);
   begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge core_clk); while (!rvalid);
      rd_d = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge core_clk);
   end
   endtask

   task automatic put(input int r, input logic [15:0] v, input logic [3:0] s);
   begin
      wr(prio_pkg::REG_OFS[r], {16'hFFFF, v}, s);
      chk(rsp, prio_pkg::RESP_OKAY);
      if (s[1])
         m[r][15:8] = v[15:8] & 8'h77;
      if (s[0])
         m[r][7:0] = v[7:0] & 8'h77;
   end
   endtask

   task automatic verify;
   begin
      for (int r = 0; r < 5; r++)
      begin
         rd(prio_pkg::REG_OFS[r]);
         chk(rd_d, {16'h0, m[r]});
         chk(rsp, prio_pkg::RESP_OKAY);
         for (int s = 0; s < 4; s++)
         begin
            d = m[r] >> prio_pkg::FLD_LSB[s];
            k = 4 * r + s;
            chk(pr[k], d[2:0]);
            chk(source_request[k], source_flag[k] && d[2:0] != 3'h0);
         end
      end
   end
   endtask

   task automatic rst;
   begin
      srst <= 1'b1;
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      m = '{default: 16'h4444};
   end
   endtask

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         failures++;
         conclude();
      end
   end

   initial
   begin
      srst = 1'b1;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      source_flag = 20'hFFFFF;
      @(posedge core_clk);
      rst();
      verify();
      $display("test reset done");
      for (int r = 0; r < 5; r++)
         put(r, 16'hFFFF, 4'hF);
      verify();
      $display("test level seven done");
      for (int r = 0; r < 5; r++)
      begin
         d = 16'h8888;
         for (int s = 0; s < 4; s++)
            d[prio_pkg::FLD_LSB[s] +: 3] = 3'((4 * r + s) % 8);
         put(r, d, 4'hF);
      end
      verify();
      $display("test codes done");
      put(0, 16'h0000, 4'h2);
      put(1, 16'h0000, 4'h1);
      source_flag <= 20'h5A5A5;
      verify();
      $display("test strobes done");
      for (int i = 0; i < 2; i++)
      begin
         wr(i ? 8'hFC : 8'h14, 32'hFFFF_FFFF, 4'hF);
         chk(rsp, prio_pkg::RESP_SLVERR);
         rd(i ? 8'hFC : 8'h14);
         chk(rd_d, 32'h0);
         chk(rsp, prio_pkg::RESP_SLVERR);
      end
      verify();
      $display("test unmapped done");
      rst();
      verify();
      $display("test second reset done");
      conclude();
   end
endmodule

bind prio_bank prio_bank_chk #(.NUM_SRC(NUM_SRC)) chk_u (
   .core_clk(core_clk), .srst(srst), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready),
   .bvalid(bvalid), .arvalid(arvalid), .arready(arready),
   .rvalid(rvalid), .rdata(rdata), .source_flag(source_flag),
   .source_request(source_request), .timer4_priority(timer4_priority),
   .in_capture6_priority(in_capture6_priority)
);
